// File: shared/adcc_pkg.sv
// Constants and types shared by the automatic dial call-control block.
// Assumes a single clock domain and synchronous inputs.
package adcc_pkg;

   // Dial character layout: bit 8 is parity, bits 7:0 the value.
   localparam int DIAL_W = 9;
   localparam int DIGIT_W = 4;
   localparam int PAR_BIT = 8;
   localparam logic [7:0] DIAL_TERM_VAL = 8'h0c;
   localparam logic [7:0] DIGIT_MAX_VAL = 8'h09;
   localparam logic [3:0] MAX_DIGITS = 4'hb;

   // Dial buffer FIFO depth.
   localparam int FIFO_DEPTH = 8;

   // Host command codes.
   localparam logic [2:0] CMD_DIAL = 3'h1;
   localparam logic [2:0] CMD_SEND_DATA = 3'h2;
   localparam logic [2:0] CMD_SENSE = 3'h3;
   localparam logic [2:0] CMD_DISCONNECT = 3'h4;
   localparam logic [2:0] CMD_TERMINATE = 3'h5;

   // Status byte flags.
   localparam logic [7:0] ST_BUSY = 8'h10;
   localparam logic [7:0] ST_CHAN_END = 8'h08;
   localparam logic [7:0] ST_DEV_END = 8'h04;
   localparam logic [7:0] ST_UNIT_CHECK = 8'h02;
   localparam logic [7:0] ST_NONE = 8'h00;

   // Sense byte flags.
   localparam logic [7:0] SN0_CMD_REJECT = 8'h80;
   localparam logic [7:0] SN0_DATA_CHECK = 8'h08;
   localparam logic [7:0] SN1_DIAL_FAILED = 8'h01;
   localparam logic [7:0] SN_NONE = 8'h00;

   // Sense sequence step values.
   localparam logic [1:0] SNS_IDLE = 2'h0;
   localparam logic [1:0] SNS_BYTE1 = 2'h1;
   localparam logic [1:0] SNS_END = 2'h2;

   // Values after reset.
   localparam logic [3:0] RST_DIGIT_CNT = 4'h0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DIALING,
      ST_AWAIT,
      ST_LINE,
      ST_FAILED
   } adcc_state_t;

endpackage

// File: src/adcc_call_ctrl.sv
// Automatic dial call control for one switched circuit: command decode,
// dial digit streaming to the calling unit, call outcome reporting,
// RTS/CTS handshake and hang-up.
// Assumes all inputs are synchronous to mclk and the host takes every
// response byte in the cycle it is presented.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Stream dial digits until terminator recognised
// - Nine-bit char: parity then unsigned value
// - Accept dial strings up to eleven digits
// - Connection reported as normal ending status
// - Abandon gives fault status from transmit side
// - Sense after failed dial reports it
// - Send-data raises RTS; data waits for CTS
// - Disconnect releases circuit and hangs up
// - One adapter and calling unit per circuit
// - Terminator code stops, never forwarded
// - Failure status: end flags, unit check; sense zero, dial-failed
// - Accepted dial answered with zero status
module adcc_call_ctrl
   import adcc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Host command port
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   output logic cmd_ready,
   // Host dial character stream
   input wire logic dial_valid,
   input wire logic [adcc_pkg::DIAL_W-1:0] dial_data,
   output logic dial_ready,
   // Host response bytes
   output logic resp_valid,
   output logic [7:0] resp_byte,
   output logic resp_is_sense,
   output logic resp_rx_side,
   // Host output data request
   output logic out_data_req,
   // Calling unit
   output logic cu_digit_valid,
   output logic [adcc_pkg::DIGIT_W-1:0] cu_digit,
   input wire logic cu_digit_ready,
   input wire logic abandon_retry_signal,
   output logic line_hold,
   // Data set
   input wire logic data_mode,
   output logic rts,
   input wire logic cts
);
   import adcc_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // State.

   adcc_state_t state_r, state_nxt;
   logic [3:0] digit_cnt_r, digit_cnt_nxt;
   logic digit_valid_r, digit_valid_nxt;
   logic [DIGIT_W-1:0] digit_r, digit_nxt;
   logic rts_r, rts_nxt;
   logic hold_r, hold_nxt;
   logic ok_pend_r, ok_pend_nxt;
   logic fail_pend_r, fail_pend_nxt;
   logic [7:0] sense0_r, sense0_nxt;
   logic [7:0] sense1_r, sense1_nxt;
   logic [1:0] sns_r, sns_nxt;
   logic rv_r, rv_nxt;
   logic [7:0] rb_r, rb_nxt;
   logic rs_r, rs_nxt;
   logic rx_r, rx_nxt;

   logic fifo_out_valid, fifo_out_ready, fifo_in_ready, fifo_flush;
   logic [DIAL_W-1:0] fifo_out_data;
   logic chk_parity_ok, chk_is_term, chk_digit_ok;
   logic [DIGIT_W-1:0] chk_digit;
   logic drain_take, cmd_take;

   //////////////////////////////////////////////////////////////////////////
   // Dial buffer and character decode.

   // Host characters are taken only while dialing; the FIFO fills when
   // the calling unit is slow, and its ready stalls the host.
   assign dial_ready = (state_r == ST_DIALING) && fifo_in_ready;
   assign fifo_out_ready = (state_r == ST_DIALING) &&
                           (!digit_valid_r || cu_digit_ready);
   assign drain_take = fifo_out_valid && fifo_out_ready;

   adcc_fifo #(
      .WIDTH(DIAL_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .flush(fifo_flush),
      .in_valid(dial_valid && dial_ready),
      .in_data(dial_data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_out_ready)
   );

   adcc_dial_check u_check (
      .dial_char(fifo_out_data),
      .parity_ok(chk_parity_ok),
      .is_term(chk_is_term),
      .digit_ok(chk_digit_ok),
      .digit(chk_digit)
   );

   //////////////////////////////////////////////////////////////////////////
   // Outputs.

   // A new command waits while a sense sequence is being delivered.
   assign cmd_ready = (sns_r == SNS_IDLE);
   assign cmd_take = cmd_valid && cmd_ready;
   // Output data is asked for only once the data set clears us to send.
   assign out_data_req = rts_r && cts;
   assign rts = rts_r;
   assign cu_digit_valid = digit_valid_r;
   assign cu_digit = digit_r;
   assign line_hold = hold_r;
   assign resp_valid = rv_r;
   assign resp_byte = rb_r;
   assign resp_is_sense = rs_r;
   assign resp_rx_side = rx_r;

   //////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      logic fail;
      fail = 1'b0;
      state_nxt = state_r;
      digit_cnt_nxt = digit_cnt_r;
      digit_valid_nxt = digit_valid_r;
      digit_nxt = digit_r;
      rts_nxt = rts_r;
      hold_nxt = hold_r;
      ok_pend_nxt = ok_pend_r;
      fail_pend_nxt = fail_pend_r;
      sense0_nxt = sense0_r;
      sense1_nxt = sense1_r;
      sns_nxt = sns_r;
      rv_nxt = 1'b0;
      rb_nxt = ST_NONE;
      rs_nxt = 1'b0;
      rx_nxt = 1'b0;
      fifo_flush = 1'b0;

      // Response byte selection: sense sequence, then command status,
      // then pending call outcome. Pending flags clear here, before any
      // new event sets them, so a set in the same cycle wins.
      if (sns_r == SNS_BYTE1) begin
         rv_nxt = 1'b1;
         rs_nxt = 1'b1;
         rb_nxt = sense1_r;
         sns_nxt = SNS_END;
      end else if (sns_r == SNS_END) begin
         rv_nxt = 1'b1;
         rb_nxt = ST_CHAN_END | ST_DEV_END;
         sns_nxt = SNS_IDLE;
         sense0_nxt = SN_NONE;
         sense1_nxt = SN_NONE;
      end else if (!cmd_take && fail_pend_r) begin
         rv_nxt = 1'b1;
         rb_nxt = ST_CHAN_END | ST_DEV_END | ST_UNIT_CHECK;
         fail_pend_nxt = 1'b0;
      end else if (!cmd_take && ok_pend_r) begin
         rv_nxt = 1'b1;
         rx_nxt = 1'b1;
         rb_nxt = ST_CHAN_END | ST_DEV_END;
         ok_pend_nxt = 1'b0;
      end

      // Digit handed to the calling unit is held until it takes it, the call fails or a disconnect is taken.
      if (digit_valid_r && cu_digit_ready) begin
         digit_valid_nxt = 1'b0;
      end

      // Drain one dial character per accepted slot.
      if (drain_take) begin
         if (!chk_parity_ok) begin
            fail = 1'b1;
            sense0_nxt = sense0_nxt | SN0_DATA_CHECK;
         end else if (chk_is_term) begin
            // Stop and drop the terminator and any trailing bytes.
            state_nxt = ST_AWAIT;
            fifo_flush = 1'b1;
         end else if (!chk_digit_ok || digit_cnt_r == MAX_DIGITS) begin
            fail = 1'b1;
            sense0_nxt = sense0_nxt | SN0_DATA_CHECK;
         end else begin
            digit_valid_nxt = 1'b1;
            digit_nxt = chk_digit;
            digit_cnt_nxt = digit_cnt_r + 1'b1;
         end
      end

      // The calling unit gives up: report failure from the transmit side.
      if ((state_r == ST_DIALING || state_r == ST_AWAIT) &&
          abandon_retry_signal) begin
         fail = 1'b1;
      end

      // The data set reports data mode once the calling unit hands over.
      if (state_r == ST_AWAIT && data_mode && !fail) begin
         state_nxt = ST_LINE;
         ok_pend_nxt = 1'b1;
      end

      if (fail) begin
         state_nxt = ST_FAILED;
         fail_pend_nxt = 1'b1;
         sense1_nxt = sense1_nxt | SN1_DIAL_FAILED;
         digit_valid_nxt = 1'b0;
         fifo_flush = 1'b1;
      end

      // Commands. A command always answers in the cycle after it is taken.
      if (cmd_take) begin
         rv_nxt = 1'b1;
         rb_nxt = ST_NONE;
         case (cmd_code)
            CMD_DIAL: begin
               if (state_r == ST_IDLE) begin
                  // Zero status before any digit moves.
                  rb_nxt = ST_NONE;
                  state_nxt = ST_DIALING;
                  hold_nxt = 1'b1;
                  digit_cnt_nxt = RST_DIGIT_CNT;
                  sense0_nxt = SN_NONE;
                  sense1_nxt = SN_NONE;
                  fifo_flush = 1'b1;
               end else begin
                  rb_nxt = ST_BUSY;
               end
            end
            CMD_SEND_DATA: begin
               rts_nxt = 1'b1;
            end
            CMD_TERMINATE: begin
               rts_nxt = 1'b0;
               rb_nxt = ST_CHAN_END | ST_DEV_END;
            end
            CMD_SENSE: begin
               // First sense byte now, second and ending status follow.
               rs_nxt = 1'b1;
               rb_nxt = sense0_r;
               sns_nxt = SNS_BYTE1;
            end
            CMD_DISCONNECT: begin
               // Hang-up acts only on this circuit's calling unit.
               hold_nxt = 1'b0;
               state_nxt = ST_IDLE;
               rts_nxt = 1'b0;
               digit_valid_nxt = 1'b0;
               ok_pend_nxt = 1'b0;
               fail_pend_nxt = 1'b0;
               fifo_flush = 1'b1;
               rx_nxt = 1'b1;
               rb_nxt = ST_CHAN_END | ST_DEV_END;
            end
            default: begin
               rb_nxt = ST_UNIT_CHECK;
               sense0_nxt = sense0_nxt | SN0_CMD_REJECT;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         digit_cnt_r <= RST_DIGIT_CNT;
         digit_valid_r <= 1'b0;
         digit_r <= '0;
         rts_r <= 1'b0;
         hold_r <= 1'b0;
         ok_pend_r <= 1'b0;
         fail_pend_r <= 1'b0;
         sense0_r <= SN_NONE;
         sense1_r <= SN_NONE;
         sns_r <= SNS_IDLE;
         rv_r <= 1'b0;
         rb_r <= ST_NONE;
         rs_r <= 1'b0;
         rx_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         digit_cnt_r <= digit_cnt_nxt;
         digit_valid_r <= digit_valid_nxt;
         digit_r <= digit_nxt;
         rts_r <= rts_nxt;
         hold_r <= hold_nxt;
         ok_pend_r <= ok_pend_nxt;
         fail_pend_r <= fail_pend_nxt;
         sense0_r <= sense0_nxt;
         sense1_r <= sense1_nxt;
         sns_r <= sns_nxt;
         rv_r <= rv_nxt;
         rb_r <= rb_nxt;
         rs_r <= rs_nxt;
         rx_r <= rx_nxt;
      end
   end
endmodule

// File: src/adcc_dial_check.sv
// Decoder for one dial character: parity, terminator and digit value.
// Purely combinational; the caller samples the outputs.
`timescale 1ns/1ns
module adcc_dial_check
   import adcc_pkg::*;
(
   // Character under test
   input wire logic [adcc_pkg::DIAL_W-1:0] dial_char,
   // Decoded results
   output logic parity_ok,
   output logic is_term,
   output logic digit_ok,
   output logic [adcc_pkg::DIGIT_W-1:0] digit
);
   import adcc_pkg::*;

   logic [7:0] value;

   assign value = dial_char[7:0];
   // Odd parity over all nine bits.
   assign parity_ok = ^dial_char;
   // The terminator is recognised by its value alone; parity_ok is reported separately.
   assign is_term = (value == DIAL_TERM_VAL);
   // Digits are plain unsigned binary in the low-order bits.
   assign digit_ok = (value <= DIGIT_MAX_VAL);
   assign digit = value[DIGIT_W-1:0];
endmodule

// File: src/adcc_fifo.sv
// Dial character buffer: a flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; flush empties it in one cycle and wins over a write.
`timescale 1ns/1ns
module adcc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic wr_en, rd_en;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign wr_en = in_valid && in_ready && !flush;
   assign rd_en = out_valid && out_ready && !flush;

   always_comb begin
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      cnt_nxt = cnt_r;
      if (flush) begin
         wr_nxt = '0;
         rd_nxt = '0;
         cnt_nxt = '0;
      end else begin
         if (wr_en) begin
            wr_nxt = (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         if (rd_en) begin
            rd_nxt = (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end
         if (wr_en && !rd_en) begin
            cnt_nxt = cnt_r + 1'b1;
         end else if (rd_en && !wr_en) begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage needs no reset; out_valid hides stale words.
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem_r[wr_r] <= in_data;
      end
   end
endmodule

// File: verif/adcc_far_model.sv
// Behavioural calling unit and data set for one dialed circuit.
// Assumes mclk is shared with the call-control block.
`timescale 1ns/1ns
module adcc_far_model
   import adcc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Bench controls
   input wire logic stall,
   input wire logic fail,
   input wire logic answer,
   // Calling unit
   input wire logic cu_digit_valid,
   input wire logic [adcc_pkg::DIGIT_W-1:0] cu_digit,
   output logic cu_digit_ready,
   output logic abandon_retry_signal,
   input wire logic line_hold,
   // Data set
   output logic data_mode,
   input wire logic rts,
   output logic cts
);
   logic [3:0] got [0:15];
   logic [4:0] n_got;
   // One model serves one circuit only, so hang-up never reaches another.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cu_digit_ready <= 1'b0;
         abandon_retry_signal <= 1'b0;
         data_mode <= 1'b0;
         cts <= 1'b0;
         n_got <= 5'h00;
      end else begin
         cu_digit_ready <= !stall;
         if (cu_digit_valid && cu_digit_ready) begin
            got[n_got[3:0]] <= cu_digit;
            n_got <= n_got + 5'h01;
         end
         abandon_retry_signal <= fail;
         data_mode <= answer && line_hold;
         // Clear-to-send stays low until the line is handed over.
         cts <= rts && data_mode && line_hold;
      end
   end
endmodule

// File: verif/adcc_props.sv
// Port checker for the call-control block, bound to its top module.
// Assumes one mclk domain and the asynchronous active-high reset.
`timescale 1ns/1ns
module adcc_props
   import adcc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Host side
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic cmd_ready,
   input wire logic dial_valid,
   input wire logic [adcc_pkg::DIAL_W-1:0] dial_data,
   input wire logic dial_ready,
   input wire logic resp_valid,
   input wire logic [7:0] resp_byte,
   input wire logic resp_is_sense,
   input wire logic resp_rx_side,
   input wire logic out_data_req,
   // Far side
   input wire logic cu_digit_valid,
   input wire logic [adcc_pkg::DIGIT_W-1:0] cu_digit,
   input wire logic cu_digit_ready,
   input wire logic abandon_retry_signal,
   input wire logic line_hold,
   input wire logic data_mode,
   input wire logic rts,
   input wire logic cts
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   logic take;
   assign take = cmd_valid && cmd_ready;
   property p_dial_ack;
      take && cmd_code == CMD_DIAL && !line_hold |=>
         resp_valid && resp_byte == ST_NONE && !resp_rx_side && line_hold;
   endproperty
   a_dial_ack: assert property (p_dial_ack)
      else $error("dial answer wrong");
   property p_send;
      take && cmd_code == CMD_SEND_DATA |=>
         rts && resp_valid && resp_byte == ST_NONE;
   endproperty
   a_send: assert property (p_send)
      else $error("send-data answer wrong");
   property p_req;
      out_data_req |-> rts && cts;
   endproperty
   a_req: assert property (p_req)
      else $error("data requested without clear-to-send");
   property p_disc;
      take && cmd_code == CMD_DISCONNECT |=> resp_valid && resp_rx_side &&
         resp_byte == 8'h0c && !line_hold && !rts && !cu_digit_valid;
   endproperty
   a_disc: assert property (p_disc)
      else $error("disconnect did not hang up");
   property p_sense;
      take && cmd_code == CMD_SENSE |=>
         (resp_valid && resp_is_sense && !cmd_ready) [*2] ##1
         (resp_valid && !resp_is_sense && resp_byte == 8'h0c && cmd_ready);
   endproperty
   a_sense: assert property (p_sense)
      else $error("sense sequence wrong");
   // An abandoned call may drop the waiting digit, so it is excluded.
   property p_hold;
      cu_digit_valid && !cu_digit_ready && !abandon_retry_signal &&
         !(take && cmd_code == CMD_DISCONNECT) |=>
         cu_digit_valid && $stable(cu_digit);
   endproperty
   a_hold: assert property (p_hold)
      else $error("digit dropped before taken");
   property p_digit;
      cu_digit_valid |-> cu_digit <= 4'h9;
   endproperty
   a_digit: assert property (p_digit)
      else $error("digit out of range");
   property p_rx_ok;
      resp_valid && resp_rx_side |-> resp_byte == 8'h0c && !resp_is_sense;
   endproperty
   a_rx_ok: assert property (p_rx_ok)
      else $error("receive side status wrong");
   c_fail: cover property (resp_valid && resp_byte == 8'h0e);
   c_full: cover property (line_hold && dial_valid && !dial_ready);
   c_data: cover property (out_data_req);
endmodule
bind adcc_call_ctrl adcc_props i_adcc_props (.mclk, .reset, .cmd_valid,
   .cmd_code, .cmd_ready, .dial_valid, .dial_data, .dial_ready, .resp_valid,
   .resp_byte, .resp_is_sense, .resp_rx_side, .out_data_req, .cu_digit_valid,
   .cu_digit, .cu_digit_ready, .abandon_retry_signal, .line_hold, .data_mode,
   .rts, .cts);

// File: verif/testbench.sv
// Self-checking bench for the call-control block and its far-side model.
// Assumes inputs move at the falling edge of mclk.
`timescale 1ns/1ns
module testbench;
   import adcc_pkg::*;
   logic mclk, reset, cmd_valid, cmd_ready, dial_valid, dial_ready;
   logic [2:0] cmd_code;
   logic [DIAL_W-1:0] dial_data;
   logic resp_valid, resp_is_sense, resp_rx_side, out_data_req;
   logic [7:0] resp_byte;
   logic cu_digit_valid, cu_digit_ready, abandon_retry_signal, line_hold;
   logic [DIGIT_W-1:0] cu_digit;
   logic data_mode, rts, cts, stall, fail, answer, ok;
   int err_total, compares, k, i;
   logic [9:0] rq [$];
   adcc_call_ctrl i_adcc_call_ctrl (.mclk, .reset, .cmd_valid, .cmd_code,
      .cmd_ready, .dial_valid, .dial_data, .dial_ready, .resp_valid,
      .resp_byte, .resp_is_sense, .resp_rx_side, .out_data_req,
      .cu_digit_valid, .cu_digit, .cu_digit_ready, .abandon_retry_signal,
      .line_hold, .data_mode, .rts, .cts);
   adcc_far_model i_adcc_far_model (.mclk, .reset, .stall, .fail, .answer,
      .cu_digit_valid, .cu_digit, .cu_digit_ready, .abandon_retry_signal,
      .line_hold, .data_mode, .rts, .cts);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(negedge mclk)
      if (resp_valid === 1'b1)
         rq.push_back({resp_is_sense, resp_rx_side, resp_byte});
   //////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic miss(string m);
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic hung();
      miss("wait ran out");
      results();
   endtask
   task automatic chk_bit(logic got, logic exp, string m);
      compares++;
      if (got !== exp) miss(m);
   endtask
   task automatic chk_byte(logic [7:0] got, logic [7:0] exp, string m);
      compares++;
      if (got !== exp) miss(m);
   endtask
   // Every command is followed by resp, which moves on by a falling edge.
   task automatic cmd(logic [2:0] code);
      cmd_valid = 1'b1;
      cmd_code = code;
      for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) @(negedge mclk);
      if (i == 20) hung();
      @(negedge mclk);
      cmd_valid = 1'b0;
   endtask
   task automatic resp(logic [9:0] exp, string m);
      for (i = 0; i < 50 && rq.size() == 0; i++) @(posedge mclk);
      if (i == 50) hung();
      chk_byte(rq[0][7:0], exp[7:0], m);
      chk_bit(rq[0][9], exp[9], m);
      chk_bit(rq[0][8], exp[8], m);
      void'(rq.pop_front());
      @(negedge mclk);
   endtask
   task automatic put(logic [7:0] v, output logic acc);
      dial_valid = 1'b1;
      dial_data = {~^v, v};
      for (i = 0; i < 4 && dial_ready !== 1'b1; i++) @(negedge mclk);
      acc = (i < 4);
      if (acc) @(negedge mclk);
      else dial_valid = 1'b0;
   endtask
   //////////////////////////////////////////////////////////////////////////
   initial begin
      {cmd_valid, cmd_code, dial_valid, dial_data} = '0;
      {stall, fail, answer} = 3'b100;
      reset = 1'b1;
      err_total = 0;
      compares = 0;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      chk_bit(cmd_ready, 1'b1, "ready after reset");
      chk_bit(line_hold | rts | dial_ready, 1'b0, "idle after reset");
      $display("reset test done");
      cmd(CMD_DIAL);
      resp(10'h000, "dial accepted");
      cmd(CMD_DIAL);
      resp(10'h010, "dial while busy");
      k = 0;
      ok = 1'b1;
      while (ok && k < 11) begin
         put(8'((k * 7) % 10), ok);
         if (ok) k++;
      end
      chk_byte(8'(k), 8'(FIFO_DEPTH + 1), "buffer fill level");
      stall = 1'b0;
      for (; k < 11; k++) begin
         put(8'((k * 7) % 10), ok);
         if (!ok) hung();
      end
      put(DIAL_TERM_VAL, ok);
      if (!ok) hung();
      dial_valid = 1'b0;
      for (i = 0; i < 100 && i_adcc_far_model.n_got < 11; i++)
         @(negedge mclk);
      if (i == 100) hung();
      repeat (5) @(negedge mclk);
      chk_byte({3'h0, i_adcc_far_model.n_got}, 8'h0b, "digit count");
      for (k = 0; k < 11; k++)
         chk_byte({4'h0, i_adcc_far_model.got[k]}, 8'((k * 7) % 10), "digit");
      chk_bit(dial_ready, 1'b0, "input closed after terminator");
      cmd(CMD_SEND_DATA);
      resp(10'h000, "send-data answer");
      repeat (3) @(negedge mclk);
      chk_bit(rts, 1'b1, "rts raised");
      chk_bit(out_data_req, 1'b0, "no data before cts");
      answer = 1'b1;
      resp(10'h10c, "call connected");
      for (i = 0; i < 10 && out_data_req !== 1'b1; i++) @(negedge mclk);
      if (i == 10) hung();
      chk_bit(out_data_req, 1'b1, "data requested after cts");
      cmd(CMD_TERMINATE);
      resp(10'h00c, "terminate answer");
      chk_bit(rts, 1'b0, "rts dropped");
      cmd(CMD_DISCONNECT);
      resp(10'h10c, "disconnect answer");
      chk_bit(line_hold, 1'b0, "line released");
      answer = 1'b0;
      $display("dial success test done");
      cmd(CMD_DIAL);
      resp(10'h000, "second dial accepted");
      put(8'h05, ok);
      if (!ok) hung();
      put(DIAL_TERM_VAL, ok);
      if (!ok) hung();
      dial_valid = 1'b0;
      fail = 1'b1;
      resp(10'h00e, "abandoned call status");
      fail = 1'b0;
      cmd(CMD_SENSE);
      resp(10'h200, "first sense byte");
      resp(10'h201, "dial failed sense");
      resp(10'h00c, "sense ending status");
      cmd(CMD_TERMINATE);
      resp(10'h00c, "terminate after failure");
      cmd(CMD_DISCONNECT);
      resp(10'h10c, "disconnect after failure");
      $display("dial failure test done");
      cmd(CMD_DIAL);
      resp(10'h000, "third dial accepted");
      put(8'h0a, ok);
      if (!ok) hung();
      dial_valid = 1'b0;
      resp(10'h00e, "bad digit status");
      cmd(CMD_SENSE);
      resp(10'h208, "data check sense byte");
      resp(10'h201, "bad digit dial failed sense");
      resp(10'h00c, "bad digit ending status");
      cmd(CMD_DISCONNECT);
      resp(10'h10c, "disconnect after bad digit");
      chk_bit(line_hold, 1'b0, "line released after bad digit");
      $display("bad digit test done");
      cmd(3'h7);
      resp(10'h002, "unknown command");
      cmd(CMD_SENSE);
      resp(10'h280, "reject sense byte");
      resp(10'h200, "second sense byte");
      resp(10'h00c, "reject ending status");
      $display("reject test done");
      results();
   end
endmodule
